// ---- design/apbs_core.sv ----
// Buffer servicing of a multichannel audio serial port: lane buffers, ready
// flags, DMA request pulses, interrupts, underrun and overrun detection.
// Assumes the serial engine pulses tx_load_i and rx_store_i once per slot.
//
// Design decisions made here: the address map and strobed register access.
`include "apbs_map.svh"

module apbs_core #(
  parameter int LANES = 4,
  parameter int WIDTH = 32
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire apbs_pkg::apbs_addr_t reg_addr_i,
  input wire apbs_pkg::apbs_word_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output apbs_pkg::apbs_word_t reg_rdata_o,
  input wire logic tx_load_i,
  output logic [LANES-1:0][WIDTH-1:0] tx_word_o,
  input wire logic rx_store_i,
  input wire logic [LANES-1:0][WIDTH-1:0] rx_word_i,
  output logic tx_dma_req_o,
  output logic rx_dma_req_o,
  output logic tx_irq_o,
  output logic rx_irq_o
);
  import apbs_pkg::*;

  localparam int LW = (LANES > 1) ? $clog2(LANES) : 1;
  localparam int DMA_LAT = `APBS_DMA_LAT_MAX;

  typedef struct packed {
    logic [LANES-1:0][WIDTH-1:0] tx_buf;
    logic [LANES-1:0][WIDTH-1:0] tx_shift;
    logic [LANES-1:0][WIDTH-1:0] rx_buf;
    logic [LANES-1:0] active;
    logic [LANES-1:0] dir;
    logic [LANES-1:0] tx_need;
    logic [LANES-1:0] rx_pend;
    logic tx_psel;
    logic rx_psel;
    logic tx_ien;
    logic rx_ien;
    logic tx_flag;
    logic rx_flag;
    logic tx_urun;
    logic rx_orun;
    logic tx_req;
    logic rx_req;
    apbs_word_t rdata;
  } apbs_state_t;

  apbs_state_t q;
  apbs_state_t d;
  logic [LANES-1:0] tx_act;
  logic [LANES-1:0] rx_act;
  logic lane_hit;
  logic [LW-1:0] idx;
  logic [LW-1:0] pick;
  logic [WIDTH-1:0] low_word;

  // The lowest pending index gives the ascending service order of the data port.
  function automatic logic [LW-1:0] first_lane(input logic [LANES-1:0] m);
    first_lane = '0;
    for (int i = LANES - 1; i >= 0; i--)
    begin
      if (m[i])
      begin
        first_lane = i[LW-1:0];
      end
    end
  endfunction

  assign tx_act = q.active & q.dir;
  assign rx_act = q.active & ~q.dir;
  assign lane_hit = (reg_addr_i >= `APBS_LANE_BASE) && (reg_addr_i[1:0] == 2'h0) &&
                    (32'(reg_addr_i) < 32'(`APBS_LANE_BASE) + 32'(LANES * 4));
  assign idx = reg_addr_i[2 +: LW];

  always_comb
  begin
    d = q;
    pick = '0;
    d.tx_req = 1'b0;
    d.rx_req = 1'b0;
    d.rdata = '0;
    if (reg_wr_i)
    begin
      if (reg_addr_i == `APBS_DATA_PORT)
      begin
        // Writes beyond the active transmitters of this slot are dropped.
        if (!q.tx_psel && (|q.tx_need))
        begin
          pick = first_lane(q.tx_need);
          d.tx_buf[pick] = reg_wdata_i[WIDTH-1:0];
          d.tx_need[pick] = 1'b0;
        end
      end
      else if (reg_addr_i == `APBS_LANE_ACTIVE)
      begin
        d.active = reg_wdata_i[LANES-1:0];
      end
      else if (reg_addr_i == `APBS_LANE_DIR)
      begin
        d.dir = reg_wdata_i[LANES-1:0];
      end
      else if (reg_addr_i == `APBS_TX_FORMAT)
      begin
        d.tx_psel = reg_wdata_i[`APBS_PORT_SEL_BIT];
      end
      else if (reg_addr_i == `APBS_RX_FORMAT)
      begin
        d.rx_psel = reg_wdata_i[`APBS_PORT_SEL_BIT];
      end
      else if (reg_addr_i == `APBS_TX_IRQ_EN)
      begin
        d.tx_ien = reg_wdata_i[`APBS_IRQ_EN_BIT];
      end
      else if (reg_addr_i == `APBS_RX_IRQ_EN)
      begin
        d.rx_ien = reg_wdata_i[`APBS_IRQ_EN_BIT];
      end
      else if (reg_addr_i == `APBS_TX_STATUS)
      begin
        if (reg_wdata_i[`APBS_READY_BIT])
        begin
          d.tx_flag = 1'b0;
        end
        if (reg_wdata_i[`APBS_ERROR_BIT])
        begin
          d.tx_urun = 1'b0;
        end
      end
      else if (reg_addr_i == `APBS_RX_STATUS)
      begin
        if (reg_wdata_i[`APBS_READY_BIT])
        begin
          d.rx_flag = 1'b0;
        end
        if (reg_wdata_i[`APBS_ERROR_BIT])
        begin
          d.rx_orun = 1'b0;
        end
      end
      else if (lane_hit && q.tx_psel && tx_act[idx])
      begin
        d.tx_buf[idx] = reg_wdata_i[WIDTH-1:0];
        d.tx_need[idx] = 1'b0;
      end
    end
    if (reg_rd_i)
    begin
      if (reg_addr_i == `APBS_DATA_PORT)
      begin
        if (!q.rx_psel && (|q.rx_pend))
        begin
          pick = first_lane(q.rx_pend);
          d.rdata[WIDTH-1:0] = q.rx_buf[pick];
          d.rx_pend[pick] = 1'b0;
        end
      end
      else if (reg_addr_i == `APBS_LANE_ACTIVE)
      begin
        d.rdata[LANES-1:0] = q.active;
      end
      else if (reg_addr_i == `APBS_LANE_DIR)
      begin
        d.rdata[LANES-1:0] = q.dir;
      end
      else if (reg_addr_i == `APBS_TX_FORMAT)
      begin
        d.rdata[`APBS_PORT_SEL_BIT] = q.tx_psel;
      end
      else if (reg_addr_i == `APBS_RX_FORMAT)
      begin
        d.rdata[`APBS_PORT_SEL_BIT] = q.rx_psel;
      end
      else if (reg_addr_i == `APBS_TX_IRQ_EN)
      begin
        d.rdata[`APBS_IRQ_EN_BIT] = q.tx_ien;
      end
      else if (reg_addr_i == `APBS_RX_IRQ_EN)
      begin
        d.rdata[`APBS_IRQ_EN_BIT] = q.rx_ien;
      end
      else if (reg_addr_i == `APBS_TX_STATUS)
      begin
        d.rdata[`APBS_READY_BIT] = q.tx_flag;
        d.rdata[`APBS_ERROR_BIT] = q.tx_urun;
      end
      else if (reg_addr_i == `APBS_RX_STATUS)
      begin
        d.rdata[`APBS_READY_BIT] = q.rx_flag;
        d.rdata[`APBS_ERROR_BIT] = q.rx_orun;
      end
      else if (lane_hit)
      begin
        if (rx_act[idx] && q.rx_psel)
        begin
          d.rdata[WIDTH-1:0] = q.rx_buf[idx];
          d.rx_pend[idx] = 1'b0;
        end
        else if (tx_act[idx])
        begin
          d.rdata[WIDTH-1:0] = q.tx_buf[idx];
        end
      end
    end
    // Flags drop once every active lane is served; a slot event below wins.
    if ((d.tx_need & tx_act) == '0)
    begin
      d.tx_flag = 1'b0;
    end
    if ((d.rx_pend & rx_act) == '0)
    begin
      d.rx_flag = 1'b0;
    end
    if (tx_load_i)
    begin
      if (|(d.tx_need & tx_act))
      begin
        d.tx_urun = 1'b1;
      end
      d.tx_shift = d.tx_buf;
      d.tx_need = tx_act;
      d.tx_flag = 1'b1;
      d.tx_req = 1'b1;
    end
    if (rx_store_i)
    begin
      if (|(d.rx_pend & rx_act))
      begin
        d.rx_orun = 1'b1;
      end
      for (int i = 0; i < LANES; i++)
      begin
        if (rx_act[i])
        begin
          d.rx_buf[i] = rx_word_i[i];
        end
      end
      d.rx_pend = rx_act;
      d.rx_flag = 1'b1;
      d.rx_req = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign tx_word_o = q.tx_shift;
  assign tx_dma_req_o = q.tx_req;
  assign rx_dma_req_o = q.rx_req;
  assign tx_irq_o = q.tx_flag & q.tx_ien;
  assign rx_irq_o = q.rx_flag & q.rx_ien;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Word that a data port read should return; kept as a net so the read check samples a signal.
  assign low_word = q.rx_buf[first_lane(q.rx_pend)];

  sequence s_rx_store;
    rx_store_i;
  endsequence
  sequence s_rx_answer;
    ##[1:DMA_LAT] rx_dma_req_o;
  endsequence

  a_rx_req_latency: assert property (s_rx_store |-> s_rx_answer)
    else $error("receive request late");
  a_rx_req_again: assert property (rx_store_i && q.rx_flag |=> rx_dma_req_o)
    else $error("receive request missing while flag set");
  a_tx_req_latency: assert property (tx_load_i |-> ##[1:DMA_LAT] tx_dma_req_o)
    else $error("transmit request late");
  a_req_pulse: assert property (tx_dma_req_o |-> $past(tx_load_i))
    else $error("transmit request without slot");
  a_rx_flag_set: assert property (rx_store_i |=> q.rx_flag && q.rx_pend == $past(rx_act))
    else $error("receive flag not set");
  a_tx_flag_set: assert property (tx_load_i |=> q.tx_flag && q.tx_need == $past(tx_act))
    else $error("transmit flag not set");
  a_rx_irq_set: assert property (rx_store_i && q.rx_ien && !reg_wr_i |=> rx_irq_o)
    else $error("receive interrupt missing");
  a_tx_irq_set: assert property (tx_load_i && q.tx_ien && !reg_wr_i |=> tx_irq_o)
    else $error("transmit interrupt missing");
  a_tx_underrun: assert property (tx_load_i && !reg_wr_i && |(q.tx_need & tx_act)
    |=> q.tx_urun)
    else $error("underrun not flagged");
  a_rx_overrun: assert property (rx_store_i && !reg_rd_i && |(q.rx_pend & rx_act)
    |=> q.rx_orun)
    else $error("overrun not flagged");
  a_rx_w1c: assert property (reg_wr_i && reg_addr_i == `APBS_RX_STATUS
    && reg_wdata_i[`APBS_READY_BIT] && !rx_store_i |=> !q.rx_flag)
    else $error("receive flag not cleared");
  a_port_read: assert property (reg_rd_i && reg_addr_i == `APBS_DATA_PORT && !q.rx_psel
    && |q.rx_pend |=> reg_rdata_o[WIDTH-1:0] == $past(low_word))
    else $error("data port read order wrong");
endmodule

// ---- shared/apbs_map.svh ----
// Register offsets and field positions of the audio port buffer servicing block.
// Assumes byte addresses on an 8-bit register port with aligned 32-bit words.
`ifndef APBS_MAP_SVH
`define APBS_MAP_SVH
`define APBS_DATA_PORT 8'h00
`define APBS_LANE_ACTIVE 8'h04
`define APBS_LANE_DIR 8'h08
`define APBS_TX_FORMAT 8'h0C
`define APBS_RX_FORMAT 8'h10
`define APBS_TX_IRQ_EN 8'h14
`define APBS_RX_IRQ_EN 8'h18
`define APBS_TX_STATUS 8'h1C
`define APBS_RX_STATUS 8'h20
`define APBS_LANE_BASE 8'h40
`define APBS_PORT_SEL_BIT 0
`define APBS_READY_BIT 0
`define APBS_ERROR_BIT 1
`define APBS_IRQ_EN_BIT 0
`define APBS_DMA_LAT_MAX 5
`endif

// ---- shared/apbs_pkg.sv ----
// Types shared by the audio port buffer servicing block and its bench.
// Assumes the register port uses 8-bit byte addresses and 32-bit data.
package apbs_pkg;
  typedef logic [7:0] apbs_addr_t;
  typedef logic [31:0] apbs_word_t;
endpackage

// ---- tb/apbs_engine_model.sv ----
// Serial engine stand-in: slot boundary pulses and the received words per lane.
// Assumes the bench calls its tasks from a process that is synced to clk_i.
module apbs_engine_model #(
  parameter int LANES = 4,
  parameter int WIDTH = 32
) (
  input wire logic clk_i,
  output logic tx_load_o,
  output logic rx_store_o,
  output logic [LANES-1:0][WIDTH-1:0] rx_word_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    tx_load_o = 1'b0;
    rx_store_o = 1'b0;
    rx_word_o = '0;
  end
  task automatic tx_slot();
    @(posedge clk_i);
    tx_load_o <= 1'b1;
    @(posedge clk_i);
    tx_load_o <= 1'b0;
  endtask
  // Words hold only in the store cycle; they flip afterwards so a late sample is caught.
  task automatic rx_slot(input logic [WIDTH-1:0] base);
    @(posedge clk_i);
    for (int n = 0; n < LANES; n++)
      rx_word_o[n] <= base + WIDTH'(n);
    rx_store_o <= 1'b1;
    @(posedge clk_i);
    for (int n = 0; n < LANES; n++)
      rx_word_o[n] <= ~(base + WIDTH'(n));
    rx_store_o <= 1'b0;
  endtask
endmodule

// ---- tb/test_audio_port_buffer_servicing.sv ----
// Self-checking bench of the buffer servicing block with a serial engine model.
// Assumes four lanes: 0 and 2 transmit, 1 and 3 receive, all active.
`include "apbs_map.svh"

module test_audio_port_buffer_servicing;
  timeunit 1ns;
  timeprecision 1ns;
  import apbs_pkg::*;
  localparam int LANES = 4;
  localparam int WIDTH = 32;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  apbs_addr_t reg_addr_i = 8'h00;
  apbs_word_t reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  apbs_word_t reg_rdata_o;
  logic tx_load_i, rx_store_i, tx_dma_req_o, rx_dma_req_o, tx_irq_o, rx_irq_o;
  logic [LANES-1:0][WIDTH-1:0] tx_word_o, rx_word_i;
  int fails = 0;
  int checks = 0;

  always #50 clk_i = ~clk_i;

  apbs_core #(.LANES(LANES), .WIDTH(WIDTH)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tx_load_i(tx_load_i),
    .tx_word_o(tx_word_o), .rx_store_i(rx_store_i), .rx_word_i(rx_word_i),
    .tx_dma_req_o(tx_dma_req_o), .rx_dma_req_o(rx_dma_req_o), .tx_irq_o(tx_irq_o),
    .rx_irq_o(rx_irq_o));

  apbs_engine_model #(.LANES(LANES), .WIDTH(WIDTH)) eng_u (.clk_i(clk_i),
    .tx_load_o(tx_load_i), .rx_store_o(rx_store_i), .rx_word_o(rx_word_i));

  task automatic tally_and_finish();
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input apbs_addr_t a, input apbs_word_t v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task automatic rd(input apbs_addr_t a, input apbs_word_t exp, input string nm);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(nm, reg_rdata_o, exp);
  endtask

  task automatic slot(input bit tx, input apbs_word_t base);
    logic req;
    if (tx)
      eng_u.tx_slot();
    else
      eng_u.rx_slot(base);
    #1;
    req = tx ? tx_dma_req_o : rx_dma_req_o;
    chk("dma_req", {31'h0, req}, 32'h1);
    @(posedge clk_i);
    #1;
    req = tx ? tx_dma_req_o : rx_dma_req_o;
    chk("dma_req_end", {31'h0, req}, 32'h0);
  endtask

  // Writes follow the request within a few cycles, well ahead of the next slot load.
  task automatic s_tx_data_port();
    slot(1'b1, 32'h0);
    chk("tx_irq", {31'h0, tx_irq_o}, 32'h1);
    rd(`APBS_TX_STATUS, 32'h1, "tx_ready");
    wr(`APBS_DATA_PORT, 32'hA0);
    wr(`APBS_DATA_PORT, 32'hA2);
    wr(`APBS_DATA_PORT, 32'hEE);
    rd(`APBS_TX_STATUS, 32'h0, "tx_ready_served");
    slot(1'b1, 32'h0);
    chk("tx_lane0", tx_word_o[0], 32'hA0);
    chk("tx_lane2", tx_word_o[2], 32'hA2);
    rd(`APBS_TX_STATUS, 32'h1, "tx_no_underrun");
    slot(1'b1, 32'h0);
    rd(`APBS_TX_STATUS, 32'h3, "tx_underrun");
    wr(`APBS_TX_STATUS, 32'h3);
    rd(`APBS_TX_STATUS, 32'h0, "tx_w1c");
    chk("tx_irq_off", {31'h0, tx_irq_o}, 32'h0);
  endtask

  task automatic s_rx_data_port();
    slot(1'b0, 32'h100);
    chk("rx_irq", {31'h0, rx_irq_o}, 32'h1);
    rd(`APBS_RX_STATUS, 32'h1, "rx_ready");
    rd(`APBS_DATA_PORT, 32'h101, "rx_lane1");
    rd(`APBS_DATA_PORT, 32'h103, "rx_lane3");
    rd(`APBS_RX_STATUS, 32'h0, "rx_ready_served");
    rd(`APBS_DATA_PORT, 32'h0, "rx_empty");
    chk("rx_irq_off", {31'h0, rx_irq_o}, 32'h0);
  endtask

  task automatic s_rx_overrun();
    slot(1'b0, 32'h200);
    slot(1'b0, 32'h300);
    rd(`APBS_RX_STATUS, 32'h3, "rx_overrun");
    wr(`APBS_RX_STATUS, 32'h3);
    rd(`APBS_RX_STATUS, 32'h0, "rx_w1c");
  endtask

  // A data port write while the per-lane route is selected must leave lane 0 untouched.
  task automatic s_config_bus();
    wr(`APBS_TX_FORMAT, 32'h1);
    wr(`APBS_RX_FORMAT, 32'h1);
    wr(`APBS_TX_IRQ_EN, 32'h0);
    rd(`APBS_TX_FORMAT, 32'h1, "tx_port_sel");
    rd(`APBS_RX_IRQ_EN, 32'h1, "rx_irq_en");
    rd(`APBS_LANE_ACTIVE, 32'hF, "lane_active");
    rd(`APBS_LANE_DIR, 32'h5, "lane_dir");
    wr(`APBS_LANE_BASE, 32'hB0);
    wr(`APBS_LANE_BASE + 8'h08, 32'hB2);
    wr(`APBS_LANE_BASE + 8'h04, 32'hDD);
    slot(1'b1, 32'h0);
    chk("cfg_lane0", tx_word_o[0], 32'hB0);
    chk("cfg_lane2", tx_word_o[2], 32'hB2);
    chk("tx_irq_masked", {31'h0, tx_irq_o}, 32'h0);
    wr(`APBS_DATA_PORT, 32'h77);
    rd(`APBS_TX_STATUS, 32'h1, "port_write_ignored");
    rd(`APBS_LANE_BASE, 32'hB0, "cfg_tx0_read");
    rd(`APBS_LANE_BASE + 8'h04, 32'h301, "cfg_rx1");
    rd(`APBS_LANE_BASE + 8'h0C, 32'h303, "cfg_rx3");
    rd(8'h3C, 32'h0, "unmapped");
  endtask

  initial
  begin
    repeat (5000) @(posedge clk_i);
    fails++;
    tally_and_finish();
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    wr(`APBS_LANE_ACTIVE, 32'hF);
    wr(`APBS_LANE_DIR, 32'h5);
    wr(`APBS_TX_FORMAT, 32'h0);
    wr(`APBS_RX_FORMAT, 32'h0);
    wr(`APBS_TX_IRQ_EN, 32'h1);
    wr(`APBS_RX_IRQ_EN, 32'h1);
    s_tx_data_port();
    s_rx_data_port();
    s_rx_overrun();
    s_config_bus();
    tally_and_finish();
  end
endmodule
